/* File: ilo_pkg.sv */
// package: constants, types and register map of the indexed literal offset address generator
package ilo_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned FIELD_W     = 8;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned ACC_BIT_POS = 8;
  localparam logic [7:0]  IDX_MAX     = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT   = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK = 4'hF;
  localparam logic [3:0]  ACC_LO_BANK = 4'h0;
  localparam logic [11:0] WIN_SPAN    = 12'h05F;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_BANK    = 8'h04;
  localparam logic [7:0]  OFS_PTR0    = 8'h08;
  localparam logic [7:0]  OFS_PTR1    = 8'h0C;
  localparam logic [7:0]  OFS_PTR2    = 8'h10;
  localparam logic [7:0]  OFS_OPC     = 8'h14;
  localparam logic [7:0]  OFS_RES     = 8'h18;
  localparam logic [7:0]  OFS_WIN     = 8'h1C;
  localparam logic [3:0]  RST_BANK    = 4'h0;
  localparam logic [11:0] RST_PTR     = 12'h000;
  localparam logic [1:0]  HTRANS_NSEQ = 2'b10;

  // operand kinds presented with an opcode
  typedef enum logic [2:0] {
    ILO_K_DIRECT   = 3'b001,
    ILO_K_INDIRECT = 3'b010,
    ILO_K_OTHER    = 3'b100
  } ilo_kind_t;

  // resolved addressing mode
  typedef enum logic [4:0] {
    ILO_M_NONE    = 5'b00001,
    ILO_M_INDEXED = 5'b00010,
    ILO_M_ACCLO   = 5'b00100,
    ILO_M_ACCHI   = 5'b01000,
    ILO_M_BANKED  = 5'b10000
  } ilo_mode_t;

  typedef struct packed {
    logic        valid;
    ilo_kind_t   kind;
    logic [1:0]  ptr_sel;
    logic [15:0] opcode;
  } ilo_req_t;

  typedef struct packed {
    logic        valid;
    ilo_mode_t   mode;
    logic [11:0] addr;
  } ilo_rsp_t;
endpackage : ilo_pkg

/* File: ilo_resolve.sv */
// operand address resolver: pure decode from opcode, bank and pointers
`timescale 1ns/10ps
module ilo_resolve (
  // control
  input  wire logic              ext_instr_enable,
  input  wire logic [3:0]        bank_select_register,
  // pointer pairs
  input  wire logic [11:0]       pointer_pair_zero,
  input  wire logic [11:0]       pointer_pair_one,
  input  wire logic [11:0]       frame_pointer_pair,
  // request and result
  input  wire ilo_pkg::ilo_req_t req,
  output ilo_pkg::ilo_rsp_t      rsp
);
  import ilo_pkg::*;
  logic             acc;
  logic [7:0]       fld;
  logic [11:0]      ptr;

  assign acc = req.opcode[ACC_BIT_POS];
  assign fld = req.opcode[FIELD_W-1:0];

  always_comb begin
    unique case (req.ptr_sel)
      2'd0:    ptr = pointer_pair_zero;
      2'd1:    ptr = pointer_pair_one;
      default: ptr = frame_pointer_pair;
    endcase
  end

  always_comb begin
    rsp.valid = req.valid;
    rsp.mode  = ILO_M_NONE;
    rsp.addr  = RST_PTR;
    unique case (req.kind)
      ILO_K_INDIRECT: begin
        // pointer used unchanged, any pair, whatever the extended setting
        rsp.addr = ptr;
      end
      ILO_K_DIRECT: begin
        if (acc) begin
          rsp.mode = ILO_M_BANKED;
          rsp.addr = {bank_select_register, fld};
        end else if (ext_instr_enable && fld <= IDX_MAX) begin
          rsp.mode = ILO_M_INDEXED;
          rsp.addr = ADDR_W'(frame_pointer_pair + {4'h0, fld});
        end else if (fld >= ACC_SPLIT) begin
          rsp.mode = ILO_M_ACCHI;
          rsp.addr = {ACC_HI_BANK, fld};
        end else begin
          rsp.mode = ILO_M_ACCLO;
          rsp.addr = {ACC_LO_BANK, fld};
        end
      end
      default: begin
        // inherent and literal forms carry no data address
        rsp.mode = ILO_M_NONE;
      end
    endcase
  end
endmodule : ilo_resolve

/* File: ilo_top.sv */
// indexed literal offset address generator with AHB-Lite register access
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/10ps
module ilo_top (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // pipeline request and resolved address
  input  wire ilo_pkg::ilo_req_t  pipe_req,
  output ilo_pkg::ilo_rsp_t       pipe_rsp,
  output logic                    in_window
);
  import ilo_pkg::*;

  logic             ext_en_r;
  logic [3:0]       bank_r;
  logic [11:0]      ptr0_r;
  logic [11:0]      ptr1_r;
  logic [11:0]      ptr2_r;
  logic [15:0]      sw_opc_r;
  logic             wr_pend_r;
  logic [7:0]       wr_ofs_r;
  logic [31:0]      hrdata_nxt;
  logic             rd_cycle;
  ilo_req_t         sw_req;
  ilo_rsp_t         sw_rsp;
  ilo_rsp_t         p_rsp;
  ilo_rsp_t         sw_res_r;
  logic             win_nxt;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans == HTRANS_NSEQ && hwrite;
      wr_ofs_r  <= haddr[7:0];
    end
  end

  // register writes in data phase; pointers keep only 12 bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_en_r <= 1'b0;
      bank_r   <= RST_BANK;
      ptr0_r   <= RST_PTR;
      ptr1_r   <= RST_PTR;
      ptr2_r   <= RST_PTR;
      sw_opc_r <= 16'h0000;
    end else if (wr_pend_r) begin
      unique case (wr_ofs_r)
        OFS_CTRL: ext_en_r <= hwdata[0];
        OFS_BANK: bank_r   <= hwdata[BANK_W-1:0];
        OFS_PTR0: ptr0_r   <= hwdata[ADDR_W-1:0];
        OFS_PTR1: ptr1_r   <= hwdata[ADDR_W-1:0];
        OFS_PTR2: ptr2_r   <= hwdata[ADDR_W-1:0];
        OFS_OPC:  sw_opc_r <= hwdata[15:0];
        default:  ;
      endcase
    end
  end

  assign sw_req = '{valid: 1'b1, kind: ILO_K_DIRECT, ptr_sel: 2'd2, opcode: sw_opc_r};

  ilo_resolve u_pipe (
    .ext_instr_enable     (ext_en_r),
    .bank_select_register (bank_r),
    .pointer_pair_zero    (ptr0_r),
    .pointer_pair_one     (ptr1_r),
    .frame_pointer_pair   (ptr2_r),
    .req                  (pipe_req),
    .rsp                  (p_rsp)
  );

  ilo_resolve u_sw (
    .ext_instr_enable     (ext_en_r),
    .bank_select_register (bank_r),
    .pointer_pair_zero    (ptr0_r),
    .pointer_pair_one     (ptr1_r),
    .frame_pointer_pair   (ptr2_r),
    .req                  (sw_req),
    .rsp                  (sw_rsp)
  );

  // window hit: indexed address lies in frame pointer .. +95
  always_comb begin
    win_nxt = p_rsp.valid && p_rsp.mode == ILO_M_INDEXED
              && ADDR_W'(p_rsp.addr - ptr2_r) <= WIN_SPAN;
  end

  // resolved address registered one cycle after the request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pipe_rsp  <= '{valid: 1'b0, mode: ILO_M_NONE, addr: 12'h000};
      in_window <= 1'b0;
      sw_res_r  <= '{valid: 1'b0, mode: ILO_M_NONE, addr: 12'h000};
    end else begin
      pipe_rsp  <= p_rsp;
      in_window <= win_nxt;
      sw_res_r  <= sw_rsp;
    end
  end

  // read data prepared in address phase, presented in data phase
  assign rd_cycle = hready && hsel && htrans == HTRANS_NSEQ && !hwrite;

  always_comb begin
    hrdata_nxt = 32'h0000_0000;
    unique case (haddr[7:0])
      OFS_CTRL: hrdata_nxt = {31'h0, ext_en_r};
      OFS_BANK: hrdata_nxt = {28'h0, bank_r};
      OFS_PTR0: hrdata_nxt = {20'h0, ptr0_r};
      OFS_PTR1: hrdata_nxt = {20'h0, ptr1_r};
      OFS_PTR2: hrdata_nxt = {20'h0, ptr2_r};
      OFS_OPC:  hrdata_nxt = {16'h0, sw_opc_r};
      OFS_RES:  hrdata_nxt = {11'h0, sw_res_r.mode, 4'h0, sw_res_r.addr};
      OFS_WIN:  hrdata_nxt = {20'h0, ADDR_W'(ptr2_r + WIN_SPAN)};
      default:  hrdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_cycle) begin
        hrdata <= hrdata_nxt;
      end
    end
  end
endmodule : ilo_top

/* File: ilo_sva.sv */
// checker on the pipeline ports of the address generator
`timescale 1ns/10ps
module ilo_sva (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // pipeline side
  input wire ilo_pkg::ilo_req_t pipe_req,
  input wire ilo_pkg::ilo_rsp_t pipe_rsp,
  input wire logic              in_window
);
  import ilo_pkg::*;
  wire logic       dir_c = pipe_req.valid && pipe_req.kind == ILO_K_DIRECT;
  wire logic       acc_c = pipe_req.opcode[ACC_BIT_POS];
  wire logic [7:0] fld   = pipe_req.opcode[7:0];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_valid; pipe_req.valid |=> pipe_rsp.valid; endproperty
  a_valid: assert property (p_valid) else $error("response valid lost");
  property p_bank;
    dir_c && acc_c |=> pipe_rsp.mode == ILO_M_BANKED && pipe_rsp.addr[7:0] == $past(fld);
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_hi;
    dir_c && !acc_c && fld >= ACC_SPLIT |=> pipe_rsp.mode == ILO_M_ACCHI && pipe_rsp.addr == {ACC_HI_BANK, $past(fld)};
  endproperty
  a_hi: assert property (p_hi) else $error("upper access bank wrong");
  property p_lo; dir_c && !acc_c && fld <= IDX_MAX |=> pipe_rsp.mode inside {ILO_M_INDEXED, ILO_M_ACCLO}; endproperty
  a_lo: assert property (p_lo) else $error("low field mode wrong");
  property p_accl; pipe_rsp.mode == ILO_M_ACCLO |-> pipe_rsp.addr <= {4'h0, IDX_MAX}; endproperty
  a_accl: assert property (p_accl) else $error("lower access bank out of range");
  property p_ind; pipe_req.valid && pipe_req.kind == ILO_K_INDIRECT |=> pipe_rsp.mode == ILO_M_NONE; endproperty
  a_ind: assert property (p_ind) else $error("indirect operand remapped");
  property p_oth;
    pipe_req.valid && pipe_req.kind == ILO_K_OTHER |=> pipe_rsp.mode == ILO_M_NONE && pipe_rsp.addr == 12'h000;
  endproperty
  a_oth: assert property (p_oth) else $error("inherent form remapped");
  property p_win; in_window |-> pipe_rsp.mode == ILO_M_INDEXED; endproperty
  a_win: assert property (p_win) else $error("window flag outside indexed mode");
  c_idx: cover property (pipe_rsp.mode == ILO_M_INDEXED && in_window);
  c_bank: cover property (pipe_rsp.mode == ILO_M_BANKED);
  c_hi: cover property (pipe_rsp.mode == ILO_M_ACCHI);
endmodule : ilo_sva
bind ilo_top ilo_sva u_ilo_sva (.hclk(hclk), .hresetn(hresetn), .pipe_req(pipe_req),
  .pipe_rsp(pipe_rsp), .in_window(in_window));

/* File: ilo_pipe_model.sv */
// pipeline stand-in issuing one operand request per call
`timescale 1ns/10ps
module ilo_pipe_model (
  // clock
  input wire logic          hclk,
  // request toward the resolver
  output ilo_pkg::ilo_req_t pipe_req
);
  import ilo_pkg::*;
  initial pipe_req = '{1'b0, ILO_K_OTHER, 2'h0, 16'h0000};
  // the idle cycle after each request carries inverted pointer and opcode fields so stale values are never trusted
  task automatic issue(input ilo_kind_t k, input logic [1:0] p, input logic [15:0] op);
    @(posedge hclk);
    pipe_req <= '{1'b1, k, p, op};
    @(posedge hclk);
    pipe_req <= '{1'b0, ILO_K_OTHER, ~p, ~op};
  endtask : issue
endmodule : ilo_pipe_model

/* File: tb_top.sv */
// self-checking bench for the address generator
`timescale 1ns/10ps
module tb_top;
  import ilo_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, in_window;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
  ilo_req_t    pipe_req;
  ilo_rsp_t    pipe_rsp;
  int          err_total = 0, check_count = 0;
  always #5 hclk = ~hclk;
  ilo_pipe_model u_ilo_pipe_model (.hclk(hclk), .pipe_req(pipe_req));
  ilo_top u_ilo_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pipe_req(pipe_req), .pipe_rsp(pipe_rsp), .in_window(in_window));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rsp(input ilo_mode_t m, input logic [11:0] a, input logic w);
    check_count++;
    if (pipe_rsp !== {1'b1, m, a} || in_window !== w) begin
      err_total++;
      $display("[FAIL] %0t operand %h win %b exp %h", $time, pipe_rsp, in_window, {1'b1, m, a});
    end
  endtask : chk_rsp
  // bounded wait for the slave to signal ready at a rising edge
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t bus ready timeout", $time);
      finish_test();
    end
  endtask : rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NSEQ;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    x = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(x, e);
  endtask : rdc
  task automatic op(input ilo_kind_t k, input logic [1:0] p, input logic [15:0] c, input ilo_mode_t m,
                    input logic [11:0] a, input logic w);
    u_ilo_pipe_model.issue(k, p, c);
    #1;
    chk_rsp(m, a, w);
  endtask : op
  task automatic t_regs();
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_PTR2, 32'h0);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    ahb(1'b1, OFS_PTR0, 32'hFFFF_FFFF);
    rdc(OFS_PTR0, 32'h0000_0FFF);
    ahb(1'b1, OFS_PTR1, 32'h0000_0ABC);
  endtask : t_regs
  task automatic t_off();
    op(ILO_K_DIRECT, 2'h2, 16'h2405, ILO_M_ACCLO, 12'h005, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h2460, ILO_M_ACCHI, 12'hF60, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h245F, ILO_M_ACCLO, 12'h05F, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h2510, ILO_M_BANKED, 12'h010, 1'b0);
  endtask : t_off
  task automatic t_on();
    ahb(1'b1, OFS_CTRL, 32'h1);
    ahb(1'b1, OFS_PTR2, 32'h120);
    ahb(1'b1, OFS_BANK, 32'h5);
    op(ILO_K_DIRECT, 2'h2, 16'h2400, ILO_M_INDEXED, 12'h120, 1'b1);
    op(ILO_K_DIRECT, 2'h2, 16'h245F, ILO_M_INDEXED, 12'h17F, 1'b1);
    op(ILO_K_DIRECT, 2'h2, 16'h2460, ILO_M_ACCHI, 12'hF60, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h24FF, ILO_M_ACCHI, 12'hFFF, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h2510, ILO_M_BANKED, 12'h510, 1'b0);
    op(ILO_K_DIRECT, 2'h2, 16'h2505, ILO_M_BANKED, 12'h505, 1'b0);
    op(ILO_K_INDIRECT, 2'h0, 16'h2400, ILO_M_NONE, 12'hFFF, 1'b0);
    op(ILO_K_INDIRECT, 2'h1, 16'h2400, ILO_M_NONE, 12'hABC, 1'b0);
    op(ILO_K_INDIRECT, 2'h2, 16'h2400, ILO_M_NONE, 12'h120, 1'b0);
    op(ILO_K_OTHER, 2'h2, 16'h0E05, ILO_M_NONE, 12'h000, 1'b0);
    rdc(OFS_WIN, 32'h17F);
  endtask : t_on
  task automatic t_wrap();
    ahb(1'b1, OFS_PTR2, 32'hFF0);
    op(ILO_K_DIRECT, 2'h2, 16'h2420, ILO_M_INDEXED, 12'h010, 1'b1);
    rdc(OFS_WIN, 32'h04F);
    ahb(1'b1, OFS_OPC, 32'h245F);
    rdc(OFS_RES, {11'h0, ILO_M_INDEXED, 4'h0, 12'h04F});
  endtask : t_wrap
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_off();
    t_on();
    t_wrap();
    finish_test();
  end
endmodule : tb_top
